//--- omc_params.svh
`ifndef OMC_PARAMS_SVH
`define OMC_PARAMS_SVH

// clock rate of mclk
`define OMC_MCLK_HZ        125000000
`define OMC_MHZ_DIV        1000000

// init delay and start-up budget, in us and in cycles
`define OMC_INIT_DELAY_US  150
`define OMC_INIT_DELAY_CYC (`OMC_INIT_DELAY_US * (`OMC_MCLK_HZ / `OMC_MHZ_DIV))
`define OMC_FULL_START_US  500
`define OMC_FULL_START_CYC (`OMC_FULL_START_US * (`OMC_MCLK_HZ / `OMC_MHZ_DIV))

// special mode select codes
`define OMC_MD_OFF         3'h0
`define OMC_MD_NVM         3'h1
`define OMC_MD_PIN_LO      3'h2
`define OMC_MD_PIN_HI      3'h5
`define OMC_MD_STARTUP     3'h6
`define OMC_MD_STARTUP_UPD 3'h7

// internal pwm frequencies for select codes 0..7, in hertz
`define OMC_PWM_F0_HZ      200000
`define OMC_PWM_F1_HZ      294100
`define OMC_PWM_F2_HZ      416700
`define OMC_PWM_F3_HZ      500000
`define OMC_PWM_F4_HZ      625000
`define OMC_PWM_F5_HZ      714300
`define OMC_PWM_F6_HZ      833000
`define OMC_PWM_F7_HZ      1000000
`define OMC_PWM_CNT_W      10

// width of the opaque analog preload fields
`define OMC_ANALOG_CFG_W   54

`endif

//--- omc_pkg.sv
`include "omc_params.svh"

package omc_pkg;

    typedef enum logic [1:0] {
        OMC_ST_RESET,
        OMC_ST_INIT,
        OMC_ST_NORMAL,
        OMC_ST_FAILSAFE
    } omc_state_e;

    // control fields held by the block, also the non-volatile image
    typedef struct packed {
        logic                           regulator_keep_on;
        logic [2:0]                     failsafe_mode_select;
        logic                           shared_pin_function_select;
        logic [2:0]                     failsafe_pwm_freq_select;
        logic [1:0]                     booster_phase_enable;
        logic                           thermal_auto_recovery;
        logic [`OMC_ANALOG_CFG_W-1:0]   analog_cfg;
    } omc_ctrl_s;

    // status seen by the serial interface and the analog core
    typedef struct packed {
        logic       core_reg_en;
        logic       chip_in_reset;
        logic       fully_operational;
        logic       fail_safe_mode;
        logic       in_fail_safe;
        logic       standalone_mode;
        logic       serial_error_flag;
        logic       write_block;
        logic       internal_pwm_sel;
        logic       independent_phase_ok;
        logic       start_timeout;
    } omc_status_s;

endpackage

//--- omc_top.sv
`timescale 1ns/10ps
`include "omc_params.svh"

module omc_top #(
    parameter int unsigned INIT_CYC  = `OMC_INIT_DELAY_CYC,
    parameter int unsigned START_CYC = `OMC_FULL_START_CYC
) (
    input  wire logic                mclk,
    input  wire logic                nrst,
    input  wire logic                por_event,
    input  wire logic                batt_above_thr,
    input  wire logic                core_above_thr,
    input  wire logic                enable1_pin,
    input  wire logic                failsafe_or_enable_pin,
    input  wire omc_pkg::omc_ctrl_s  nvm_ctrl,
    input  wire logic                nvm_lock,
    input  wire logic                nvm_programmed,
    input  wire logic                host_wr,
    input  wire omc_pkg::omc_ctrl_s  host_wr_data,
    input  wire logic                status_rd,
    input  wire logic                frame_invalid,
    output omc_pkg::omc_ctrl_s       ctrl_eff,
    output omc_pkg::omc_status_s     status,
    output logic                     nvm_refresh,
    output logic                     int_pwm
);

    omc_pkg::omc_state_e          state_r;
    omc_pkg::omc_state_e          state_nxt;
    omc_pkg::omc_ctrl_s           ctrl_r;
    omc_pkg::omc_ctrl_s           boot_ctrl;
    logic [2:0]                   en1_sync_r;
    logic [2:0]                   en2_sync_r;
    logic [14:0]                  init_cnt_r;
    logic [16:0]                  start_cnt_r;
    logic                         start_run_r;
    logic                         pin_entered_r;
    logic                         sa_r;
    logic                         md_upd_r;
    logic                         fs_flag_r;
    logic                         spi_err_r;
    logic [`OMC_PWM_CNT_W-1:0]    pwm_cnt_r;
    logic [`OMC_PWM_CNT_W-1:0]    pwm_period;
    logic                         en_any;
    logic                         en2_fall;
    logic                         en2_rise;
    logic                         en_rise;
    logic                         supply_ok;
    logic                         leave;
    logic                         init_done;
    logic                         nvm_ok;
    logic                         startup_entry;
    logic                         pin_entry;
    logic                         fs_enter;
    logic                         fs_exit;
    logic                         in_fs;
    logic                         write_block;
    logic                         wr_ok;
    logic                         pinsel_rise;
    logic                         host_exit;

    // fail-safe serial updates only for codes 3, 5 and 7
    function automatic logic upd_enabled(input logic [2:0] md);
        upd_enabled = md[0] && (md >= 3'h3);
    endfunction

    // pwm period in mclk cycles; odd periods give one extra low cycle
    function automatic logic [`OMC_PWM_CNT_W-1:0] pwm_cycles(input logic [2:0] sel);
        int unsigned f;
        f = `OMC_PWM_F0_HZ;
        case (sel)
            3'h0: f = `OMC_PWM_F0_HZ;
            3'h1: f = `OMC_PWM_F1_HZ;
            3'h2: f = `OMC_PWM_F2_HZ;
            3'h3: f = `OMC_PWM_F3_HZ;
            3'h4: f = `OMC_PWM_F4_HZ;
            3'h5: f = `OMC_PWM_F5_HZ;
            3'h6: f = `OMC_PWM_F6_HZ;
            default: f = `OMC_PWM_F7_HZ;
        endcase
        pwm_cycles = `OMC_PWM_CNT_W'(`OMC_MCLK_HZ / f);
    endfunction

    // two-flop synchronisers; stage 2 and 3 feed the edge detectors
    always_ff @(posedge mclk or posedge por_event) begin
        if (por_event) begin
            en1_sync_r <= 3'h0;
            en2_sync_r <= 3'h0;
        end else if (!nrst) begin
            en1_sync_r <= 3'h0;
            en2_sync_r <= 3'h0;
        end else begin
            en1_sync_r <= {en1_sync_r[1:0], enable1_pin};
            en2_sync_r <= {en2_sync_r[1:0], failsafe_or_enable_pin};
        end
    end

    assign en_any    = en1_sync_r[1] | en2_sync_r[1];
    assign en2_fall  = en2_sync_r[2] & ~en2_sync_r[1];
    assign en2_rise  = ~en2_sync_r[2] & en2_sync_r[1];
    assign en_rise   = en2_rise | (~en1_sync_r[2] & en1_sync_r[1]);
    assign supply_ok = batt_above_thr & core_above_thr;
    // keep bit overrides the enables; losing a supply always resets
    assign leave     = !supply_ok || (!ctrl_r.regulator_keep_on && !en_any);
    assign init_done = (state_r == omc_pkg::OMC_ST_INIT)
                       && (init_cnt_r == 15'(INIT_CYC - 1));

    // power-up image: an unlocked memory behaves as code 0
    assign nvm_ok = nvm_lock & nvm_programmed;
    always_comb begin
        boot_ctrl = '0;
        if (nvm_ok) begin
            case (nvm_ctrl.failsafe_mode_select)
                3'h1, 3'h4, 3'h5, 3'h6, 3'h7: begin
                    boot_ctrl = nvm_ctrl;
                    boot_ctrl.thermal_auto_recovery =
                        (nvm_ctrl.failsafe_mode_select == `OMC_MD_NVM)
                        & nvm_ctrl.thermal_auto_recovery;
                end
                default: begin
                    boot_ctrl = '0;
                end
            endcase
            boot_ctrl.failsafe_mode_select = nvm_ctrl.failsafe_mode_select;
        end
    end

    // entry and exit conditions of fail-safe
    assign startup_entry = nvm_ok
        && (boot_ctrl.failsafe_mode_select >= `OMC_MD_STARTUP)
        && !boot_ctrl.shared_pin_function_select;
    assign pin_entry = en2_fall && nvm_lock
        && !ctrl_r.shared_pin_function_select
        && (((ctrl_r.failsafe_mode_select >= `OMC_MD_PIN_LO)
             && (ctrl_r.failsafe_mode_select <= `OMC_MD_PIN_HI))
            || ((ctrl_r.failsafe_mode_select == `OMC_MD_STARTUP_UPD) && md_upd_r));
    assign in_fs       = (state_r == omc_pkg::OMC_ST_FAILSAFE);
    assign write_block = in_fs && !upd_enabled(ctrl_r.failsafe_mode_select);
    assign wr_ok       = host_wr && !write_block;
    assign pinsel_rise = wr_ok && !ctrl_r.shared_pin_function_select
                         && host_wr_data.shared_pin_function_select;
    assign host_exit   = wr_ok && (host_wr_data.failsafe_mode_select <= `OMC_MD_NVM);
    assign fs_exit     = (pin_entered_r && en2_rise && !ctrl_r.shared_pin_function_select)
                         || pinsel_rise || host_exit;

    // mode sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            omc_pkg::OMC_ST_RESET: begin
                if (supply_ok && en_any)
                    state_nxt = omc_pkg::OMC_ST_INIT;
            end
            omc_pkg::OMC_ST_INIT: begin
                if (leave)
                    state_nxt = omc_pkg::OMC_ST_RESET;
                else if (init_done && startup_entry)
                    state_nxt = omc_pkg::OMC_ST_FAILSAFE;
                else if (init_done)
                    state_nxt = omc_pkg::OMC_ST_NORMAL;
            end
            omc_pkg::OMC_ST_NORMAL: begin
                if (leave)
                    state_nxt = omc_pkg::OMC_ST_RESET;
                else if (pin_entry)
                    state_nxt = omc_pkg::OMC_ST_FAILSAFE;
            end
            omc_pkg::OMC_ST_FAILSAFE: begin
                if (leave)
                    state_nxt = omc_pkg::OMC_ST_RESET;
                else if (fs_exit)
                    state_nxt = omc_pkg::OMC_ST_NORMAL;
            end
            default: begin
                state_nxt = omc_pkg::OMC_ST_RESET;
            end
        endcase
    end

    assign fs_enter = (state_nxt == omc_pkg::OMC_ST_FAILSAFE) && !in_fs;

    always_ff @(posedge mclk or posedge por_event) begin
        if (por_event)
            state_r <= omc_pkg::OMC_ST_RESET;
        else if (!nrst)
            state_r <= omc_pkg::OMC_ST_RESET;
        else
            state_r <= state_nxt;
    end

    // init delay counter, restarted whenever init is left
    always_ff @(posedge mclk or posedge por_event) begin
        if (por_event)
            init_cnt_r <= 15'h0000;
        else if (!nrst || state_r != omc_pkg::OMC_ST_INIT)
            init_cnt_r <= 15'h0000;
        else if (!init_done)
            init_cnt_r <= init_cnt_r + 15'h0001;
    end

    // memory refresh request, one pulse on entering init
    always_ff @(posedge mclk or posedge por_event) begin
        if (por_event)
            nvm_refresh <= 1'b0;
        else if (!nrst)
            nvm_refresh <= 1'b0;
        else
            nvm_refresh <= (state_r == omc_pkg::OMC_ST_RESET)
                           && (state_nxt == omc_pkg::OMC_ST_INIT);
    end

    // control fields: power-up image, fail-safe reload, host writes
    always_ff @(posedge mclk or posedge por_event) begin
        if (por_event) begin
            ctrl_r <= '0;
        end else if (!nrst || state_r == omc_pkg::OMC_ST_RESET) begin
            ctrl_r <= '0;
        end else if (init_done) begin
            ctrl_r <= boot_ctrl;
        end else if (fs_enter) begin
            // mode field and thermal recovery are not part of the reload
            ctrl_r.regulator_keep_on          <= nvm_ctrl.regulator_keep_on;
            ctrl_r.shared_pin_function_select <= nvm_ctrl.shared_pin_function_select;
            ctrl_r.failsafe_pwm_freq_select   <= nvm_ctrl.failsafe_pwm_freq_select;
            ctrl_r.booster_phase_enable       <= nvm_ctrl.booster_phase_enable;
            ctrl_r.analog_cfg                 <= nvm_ctrl.analog_cfg;
        end else if (wr_ok) begin
            ctrl_r <= host_wr_data;
        end
    end

    // how fail-safe was entered; cleared on leaving it
    always_ff @(posedge mclk or posedge por_event) begin
        if (por_event) begin
            pin_entered_r <= 1'b0;
            sa_r          <= 1'b0;
        end else if (!nrst || state_nxt != omc_pkg::OMC_ST_FAILSAFE) begin
            pin_entered_r <= 1'b0;
            sa_r          <= 1'b0;
        end else if (fs_enter) begin
            pin_entered_r <= (state_r == omc_pkg::OMC_ST_NORMAL);
            sa_r          <= (state_r == omc_pkg::OMC_ST_INIT);
        end
    end

    // code 7 arms pin entry only after the host has written it
    always_ff @(posedge mclk or posedge por_event) begin
        if (por_event)
            md_upd_r <= 1'b0;
        else if (!nrst || state_r == omc_pkg::OMC_ST_RESET)
            md_upd_r <= 1'b0;
        else if (wr_ok)
            md_upd_r <= (host_wr_data.failsafe_mode_select == `OMC_MD_STARTUP_UPD);
    end

    // sticky flags; a set in the read cycle wins over the clear
    always_ff @(posedge mclk or posedge por_event) begin
        if (por_event) begin
            fs_flag_r <= 1'b0;
            spi_err_r <= 1'b0;
        end else if (!nrst) begin
            fs_flag_r <= 1'b0;
            spi_err_r <= 1'b0;
        end else begin
            if (fs_enter)
                fs_flag_r <= 1'b1;
            else if (status_rd && !write_block)
                fs_flag_r <= 1'b0;
            if (frame_invalid)
                spi_err_r <= 1'b1;
            else if (status_rd && !write_block)
                spi_err_r <= 1'b0;
        end
    end

    // start-up watchdog from an enable rising edge to full operation
    always_ff @(posedge mclk or posedge por_event) begin
        if (por_event) begin
            start_cnt_r <= 17'h00000;
            start_run_r <= 1'b0;
        end else if (!nrst || status.fully_operational) begin
            start_cnt_r <= 17'h00000;
            start_run_r <= 1'b0;
        end else if (en_rise) begin
            start_cnt_r <= 17'h00000;
            start_run_r <= 1'b1;
        end else if (start_run_r && start_cnt_r != 17'(START_CYC)) begin
            start_cnt_r <= start_cnt_r + 17'h00001;
        end
    end

    // internal 50% pwm, runs only in pin-entered or stand-alone fail-safe
    assign pwm_period = pwm_cycles(ctrl_r.failsafe_pwm_freq_select);
    always_ff @(posedge mclk or posedge por_event) begin
        if (por_event) begin
            pwm_cnt_r <= '0;
            int_pwm   <= 1'b0;
        end else if (!nrst || !(pin_entered_r || sa_r)) begin
            pwm_cnt_r <= '0;
            int_pwm   <= 1'b0;
        end else begin
            if (pwm_cnt_r >= pwm_period - `OMC_PWM_CNT_W'(1))
                pwm_cnt_r <= '0;
            else
                pwm_cnt_r <= pwm_cnt_r + `OMC_PWM_CNT_W'(1);
            int_pwm <= (pwm_cnt_r < (pwm_period >> 1));
        end
    end

    // effective control fields: register plus forced bits
    always_ff @(posedge mclk or posedge por_event) begin
        if (por_event) begin
            ctrl_eff <= '0;
        end else if (!nrst) begin
            ctrl_eff <= '0;
        end else begin
            ctrl_eff <= ctrl_r;
            ctrl_eff.thermal_auto_recovery <= ctrl_r.thermal_auto_recovery | in_fs;
            // forcing ends with the mode, so preloaded zeros disable phases
            ctrl_eff.booster_phase_enable <=
                ctrl_r.booster_phase_enable | {2{pin_entered_r}};
        end
    end

    // registered status view
    always_ff @(posedge mclk or posedge por_event) begin
        if (por_event) begin
            status               <= '0;
            status.chip_in_reset <= 1'b1;
        end else if (!nrst) begin
            status               <= '0;
            status.chip_in_reset <= 1'b1;
        end else begin
            status.core_reg_en          <= (state_r != omc_pkg::OMC_ST_RESET);
            status.chip_in_reset        <= (state_r == omc_pkg::OMC_ST_RESET);
            status.fully_operational    <= (state_r == omc_pkg::OMC_ST_NORMAL) || in_fs;
            status.fail_safe_mode       <= fs_flag_r;
            status.in_fail_safe         <= in_fs;
            status.standalone_mode      <= sa_r;
            status.serial_error_flag    <= spi_err_r;
            status.write_block          <= write_block;
            status.internal_pwm_sel     <= pin_entered_r | sa_r;
            status.independent_phase_ok <= ctrl_r.shared_pin_function_select & ~in_fs;
            status.start_timeout        <= start_run_r && (start_cnt_r == 17'(START_CYC));
        end
    end

endmodule

//--- omc_nvm_model.sv
`timescale 1ns/10ps
// customer memory stand-in: a fixed image per mode code and pwm frequency code
module omc_nvm_model (
    input  wire logic [2:0]    code,
    input  wire logic [2:0]    freq,
    input  wire logic          locked,
    output omc_pkg::omc_ctrl_s nvm_ctrl,
    output logic               nvm_lock,
    output logic               nvm_programmed
);
    // phases stored as zero so a fail-safe exit shows them dropping back
    always_comb begin
        nvm_ctrl = '0;
        nvm_ctrl.regulator_keep_on = 1'h1;
        nvm_ctrl.failsafe_mode_select = code;
        nvm_ctrl.failsafe_pwm_freq_select = freq;
        nvm_ctrl.thermal_auto_recovery = 1'h1;
        nvm_ctrl.analog_cfg = 54'h2A_5A5A_C3C3_0F0F;
    end

    // lock from the bench; always programmed
    assign nvm_lock = locked;
    assign nvm_programmed = 1'h1;
endmodule

//--- omc_top_properties.sv
`timescale 1ns/10ps
// port-level checks of the mode sequencer
module omc_props #(
    parameter int unsigned INIT_CYC  = 20,
    parameter int unsigned START_CYC = 100
) (
    input wire logic                 mclk,
    input wire logic                 nrst,
    input wire logic                 por_event,
    input wire logic                 batt_above_thr,
    input wire logic                 core_above_thr,
    input wire logic                 enable1_pin,
    input wire logic                 failsafe_or_enable_pin,
    input wire logic                 nvm_lock,
    input wire logic                 status_rd,
    input wire logic                 frame_invalid,
    input wire omc_pkg::omc_ctrl_s   ctrl_eff,
    input wire omc_pkg::omc_status_s status,
    input wire logic                 nvm_refresh,
    input wire logic                 int_pwm
);
    localparam int START_B = START_CYC;

    // the por check must not be disabled by por itself
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst || por_event);

    a_por_clears: assert property (disable iff (!nrst)
        por_event |-> status.chip_in_reset && ctrl_eff == '0 && !int_pwm) else $error("por hold");
    a_init_span: assert property (nvm_refresh |->
        ##INIT_CYC !status.fully_operational ##1 status.fully_operational) else $error("init span");
    a_start_bound: assert property ($rose(enable1_pin) && batt_above_thr && core_above_thr
        && !status.core_reg_en |-> ##[1:START_B] status.fully_operational) else $error("start");
    a_keep_stays: assert property (ctrl_eff.regulator_keep_on && batt_above_thr
        && core_above_thr && status.core_reg_en |=> status.core_reg_en) else $error("keep on");
    a_keep_off: assert property ((!ctrl_eff.regulator_keep_on && !enable1_pin
        && !failsafe_or_enable_pin)[*4] |-> ##[0:3] status.chip_in_reset) else $error("keep off");
    a_lock_needed: assert property (!nvm_lock |-> !status.in_fail_safe)
        else $error("no lock");
    a_sel_exits: assert property (ctrl_eff.shared_pin_function_select[*2]
        |-> !status.in_fail_safe) else $error("select in fail-safe");
    a_recov_forced: assert property (status.in_fail_safe && $past(status.in_fail_safe)
        |-> ctrl_eff.thermal_auto_recovery) else $error("recovery bit low");
    a_phase_forced: assert property (status.in_fail_safe && $past(status.in_fail_safe)
        && !status.standalone_mode |-> ctrl_eff.booster_phase_enable == 2'h3
        && !status.independent_phase_ok) else $error("phases not forced");
    a_flag_clear: assert property (status_rd && status.in_fail_safe && !status.write_block
        |-> ##2 !status.fail_safe_mode) else $error("flag not cleared");
    a_err_flag: assert property (frame_invalid |-> ##[1:2] status.serial_error_flag)
        else $error("no serial error");
endmodule

bind omc_top omc_props #(.INIT_CYC(INIT_CYC), .START_CYC(START_CYC)) u_props (
    .mclk(mclk), .nrst(nrst), .por_event(por_event), .batt_above_thr(batt_above_thr),
    .core_above_thr(core_above_thr), .enable1_pin(enable1_pin), .nvm_lock(nvm_lock),
    .failsafe_or_enable_pin(failsafe_or_enable_pin), .status_rd(status_rd),
    .frame_invalid(frame_invalid), .ctrl_eff(ctrl_eff), .status(status),
    .nvm_refresh(nvm_refresh), .int_pwm(int_pwm));

//--- tb_top.sv
`timescale 1ns/10ps
module tb_top;
    localparam int unsigned INIT_CYC  = 20;
    localparam int unsigned START_CYC = 100;

    logic                 mclk = 1'h0;
    logic                 nrst = 1'h0;
    logic                 por_event = 1'h1;
    logic                 batt_above_thr = 1'h1;
    logic                 core_above_thr = 1'h1;
    logic                 enable1_pin = 1'h0;
    logic                 failsafe_or_enable_pin = 1'h0;
    logic                 host_wr = 1'h0;
    logic                 status_rd = 1'h0;
    logic                 frame_invalid = 1'h0;
    logic                 nv_locked = 1'h0;
    logic [2:0]           nv_code = 3'h0;
    logic [2:0]           nv_freq = 3'h0;
    logic                 nvm_lock, nvm_programmed, nvm_refresh, int_pwm;
    omc_pkg::omc_ctrl_s   host_wr_data = '0;
    omc_pkg::omc_ctrl_s   nvm_ctrl, ctrl_eff, e;
    omc_pkg::omc_status_s status;
    int                   bad_count = 0;
    int                   checked = 0;
    int                   per_tab [8] = '{625, 425, 299, 250, 200, 174, 150, 125};

    omc_nvm_model NVM (.code(nv_code), .freq(nv_freq), .locked(nv_locked),
        .nvm_ctrl(nvm_ctrl), .nvm_lock(nvm_lock), .nvm_programmed(nvm_programmed));

    omc_top #(.INIT_CYC(INIT_CYC), .START_CYC(START_CYC)) DUT (.mclk(mclk), .nrst(nrst),
        .por_event(por_event), .batt_above_thr(batt_above_thr), .core_above_thr(core_above_thr),
        .enable1_pin(enable1_pin), .failsafe_or_enable_pin(failsafe_or_enable_pin),
        .nvm_ctrl(nvm_ctrl), .nvm_lock(nvm_lock), .nvm_programmed(nvm_programmed),
        .host_wr(host_wr), .host_wr_data(host_wr_data), .status_rd(status_rd),
        .frame_invalid(frame_invalid), .ctrl_eff(ctrl_eff), .status(status),
        .nvm_refresh(nvm_refresh), .int_pwm(int_pwm));

    initial begin
        forever #4 mclk = ~mclk;
    end

    task automatic chk(string what, logic [64:0] seen, logic [64:0] expv);
        checked++;
        if (seen !== expv) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, expv, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // run needs near 3k cycles
    initial begin
        repeat (40000) @(posedge mclk);
        bad_count++;
        complete_run();
    end

    // image only for codes 1,4..7; mode field kept if locked
    function automatic omc_pkg::omc_ctrl_s boot_exp(logic [2:0] c, logic l);
        omc_pkg::omc_ctrl_s x;
        x = (l && c inside {3'h1, [3'h4:3'h7]}) ? nvm_ctrl : '0;
        x.failsafe_mode_select = l ? c : 3'h0;
        x.thermal_auto_recovery = l && (c == 3'h1 || c >= 3'h6);
        return x;
    endfunction

    // drivers move on the falling edge
    task automatic power_up(logic [2:0] c, logic [2:0] f, logic l);
        int t = 0;
        int r = -100;
        nrst = 1'h0;
        enable1_pin = 1'h0;
        failsafe_or_enable_pin = 1'h0;
        nv_code = c;
        nv_freq = f;
        nv_locked = l;
        repeat (3) @(negedge mclk);
        nrst = 1'h1;
        @(negedge mclk);
        enable1_pin = 1'h1;
        failsafe_or_enable_pin = 1'h1;
        while (status.fully_operational !== 1'h1 && t < START_CYC) begin
            @(negedge mclk);
            t++;
            if (nvm_refresh === 1'h1) r = t;
        end
        chk("start time", t < START_CYC, 1'h1);
        chk("init span", t - r, INIT_CYC + 1);
        chk("timeout", status.start_timeout, 1'h0);
        chk("boot ctrl", ctrl_eff, boot_exp(c, l));
        chk("core regulator", status.core_reg_en, 1'h1);
        chk("standalone", status.standalone_mode, l && c >= 3'h6);
    endtask

    task automatic pin(logic v);
        failsafe_or_enable_pin = v;
        repeat (8) @(negedge mclk);
    endtask

    task automatic wr(omc_pkg::omc_ctrl_s d);
        host_wr = 1'h1;
        host_wr_data = d;
        @(negedge mclk);
        host_wr = 1'h0;
        repeat (3) @(negedge mclk);
    endtask

    task automatic rd();
        status_rd = 1'h1;
        @(negedge mclk);
        status_rd = 1'h0;
        repeat (3) @(negedge mclk);
    endtask

    task automatic pwm_chk(int k);
        int hi = 0;
        int lo = 0;
        while (int_pwm !== 1'h1 && lo < 700) begin @(negedge mclk); lo++; end
        lo = 0;
        while (int_pwm === 1'h1 && hi < 700) begin @(negedge mclk); hi++; end
        while (int_pwm === 1'h0 && lo < 700) begin @(negedge mclk); lo++; end
        chk("pwm high", hi, per_tab[k] / 2);
        chk("pwm period", hi + lo, per_tab[k]);
    endtask

    initial begin
        @(negedge mclk);
        por_event = 1'h0;
        repeat (3) @(negedge mclk);
        chk("in reset", status.chip_in_reset, 1'h1);
        // every mode code: boot load; pin entry for codes 2..5 (none for 0 and 1), pin exit for 2..5, start-up entry for 6 and 7
        for (int c = 0; c < 8; c++) begin
            power_up(3'(c), 3'(c), 1'h1);
            if (c < 6) begin
                pin(1'h0);
                chk("pin entry", status.in_fail_safe, c >= 2);
                if (c >= 2) begin
                    e = nvm_ctrl;
                    e.thermal_auto_recovery = 1'h1;
                    e.booster_phase_enable = 2'h3;
                    chk("fs ctrl", ctrl_eff, e);
                    chk("fs flag", status.fail_safe_mode, 1'h1);
                    chk("pwm sel", status.internal_pwm_sel, 1'h1);
                    chk("phase ctl", status.independent_phase_ok, 1'h0);
                    chk("wr block", status.write_block, c == 2 || c == 4);
                    pin(1'h1);
                    e.thermal_auto_recovery = 1'h0;
                    e.booster_phase_enable = 2'h0;
                    chk("exit ctrl", ctrl_eff, e);
                end
            end else begin
                chk("startup fs", status.in_fail_safe, 1'h1);
            end
        end
        // code 7 fail-safe left by a mode write; keep bit
        e = nvm_ctrl;
        e.failsafe_mode_select = 3'h0;
        wr(e);
        chk("mode exit", status.in_fail_safe, 1'h0);
        chk("written ctrl", ctrl_eff, e);
        enable1_pin = 1'h0;
        pin(1'h0);
        chk("keep holds", status.core_reg_en, 1'h1);
        e.regulator_keep_on = 1'h0;
        wr(e);
        repeat (4) @(negedge mclk);
        chk("keep off", status.chip_in_reset, 1'h1);
        chk("reg off", status.core_reg_en, 1'h0);
        batt_above_thr = 1'h0;
        enable1_pin = 1'h1;
        repeat (8) @(negedge mclk);
        chk("supply low", status.chip_in_reset, 1'h1);
        batt_above_thr = 1'h1;
        // code 3: read clears flag; select write exits, forbids
        power_up(3'h3, 3'h1, 1'h1);
        pin(1'h0);
        rd();
        chk("flag read", status.fail_safe_mode, 1'h0);
        e = nvm_ctrl;
        e.shared_pin_function_select = 1'h1;
        wr(e);
        chk("select exit", status.in_fail_safe, 1'h0);
        pin(1'h1);
        pin(1'h0);
        chk("select blocks", status.in_fail_safe, 1'h0);
        // code 2: writes, clears refused; bad frames flagged
        power_up(3'h2, 3'h0, 1'h1);
        pin(1'h0);
        wr('0);
        chk("write refused", status.in_fail_safe, 1'h1);
        frame_invalid = 1'h1;
        @(negedge mclk);
        frame_invalid = 1'h0;
        rd();
        chk("serial err", status.serial_error_flag, 1'h1);
        chk("clear refused", status.fail_safe_mode, 1'h1);
        // unlocked memory never enters
        power_up(3'h4, 3'h0, 1'h0);
        pin(1'h0);
        chk("unlocked", status.in_fail_safe, 1'h0);
        for (int k = 0; k < 8; k++) begin
            power_up(3'h6, 3'(k), 1'h1);
            pwm_chk(k);
        end
        // power-on event acts between clock edges
        por_event = 1'h1;
        #1;
        chk("por async", status.chip_in_reset, 1'h1);
        chk("por ctrl", ctrl_eff, '0);
        @(negedge mclk);
        por_event = 1'h0;
        complete_run();
    end
endmodule
